// File: rtl/psda_params.svh
// Purpose: constants for the program space data access bridge
// Assumes: one clock, synchronous active-high reset
// Notes:   offsets, field positions and counts only
`ifndef PSDA_PARAMS_SVH
`define PSDA_PARAMS_SVH
`define PSDA_CFG_SPACE_BIT   7
`define PSDA_WIN_ENABLE_BIT  2
`define PSDA_EA_MSB          15
`define PSDA_WIN_LOW_BITS    15
`define PSDA_MOVE_STALL      2'h1
`define PSDA_OTHER_STALL     2'h2
`define PSDA_FAST_STALL      2'h0
`define PSDA_ROW_WORDS       7'h40
`define PSDA_PAGE_WORDS      10'h200
`define PSDA_ROW_BYTES       8'hC0
`define PSDA_PAGE_BYTES      11'h600
`endif

// File: rtl/psda_pkg.sv
// Purpose: types for the program space data access bridge
// Assumes: 24-bit program word, 16-bit data word
// Notes:   request and answer travel as packed structs
package psda_pkg;
    typedef enum logic [2:0] {
        PSDA_OP_NONE  = 3'b000,
        PSDA_OP_RDLO  = 3'b001,
        PSDA_OP_RDHI  = 3'b010,
        PSDA_OP_WRLO  = 3'b011,
        PSDA_OP_WRHI  = 3'b100,
        PSDA_OP_DATA  = 3'b101
    } psda_op_e;
    typedef enum logic [1:0] {
        PSDA_PROG_USER = 2'b00,
        PSDA_PROG_CFG  = 2'b01,
        PSDA_PROG_WIN  = 2'b10,
        PSDA_PROG_RAM  = 2'b11
    } psda_space_e;
    typedef struct packed {
        psda_op_e    op;
        logic        byteMode;
        logic [15:0] effAddr;
        logic [15:0] wrData;
        logic        isMove;
        logic        inRepeat;
        logic        repFirst;
        logic        repLast;
        logic        irqExit;
        logic        irqReentry;
    } psda_req_s;
    typedef struct packed {
        logic        valid;
        psda_space_e space;
        logic [23:0] progAddr;
        logic        progRead;
        logic        progWrite;
        logic [23:0] progWrData;
        logic [2:0]  progWrLanes;
        logic [15:0] ramAddr;
        logic [1:0]  stallCycles;
    } psda_cmd_s;
endpackage

// File: rtl/psda_bridge.sv
// Purpose: maps core data accesses onto program memory (table ops and window)
// Assumes: request is synchronous to ref_clk; program read data valid with request
// Notes:   one registered stage; flash erase/program sequencing lives elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "psda_params.svh"

// Functional notes
// - program memory as two parallel 16-bit spaces
// - program words step by two addresses
// - table ops support byte and word sizes
// - word low read returns P15:0 unchanged
// - byte low read picks byte by select
// - word high read returns P23:16, upper zero
// - byte high read phantom byte reads zero
// - table page bit 7 selects configuration space
// - table location from EA within page
// - upper data half maps to program page
// - window only when EA msb and enable
// - window page gives upper bits, EA low 15
// - window reads return only low 16 bits
// - window disabled during table operations
// - window stall: move one, others two
// - repeat loop: edge iterations two, others none
// - rows 64 words, pages 512 words
// - table address is page concatenated with EA
// - window address bit 15 from page bit 0
module psda_bridge
    import psda_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire psda_req_s   req,
    input  wire logic [7:0]  table_page_select,
    input  wire logic [7:0]  visibility_page_select,
    input  wire logic [15:0] core_control_reg,
    input  wire logic [23:0] progRdData,
    input  wire logic [15:0] ramRdData,
    output var  psda_cmd_s   cmd_q,
    output var  logic [15:0] rdData_q,
    output var  logic        rdValid_q,
    output var  logic        tableBusy_q,
    output var  logic [5:0]  rowIndex_q,
    output var  logic [8:0]  pageIndex_q,
    output var  logic [15:0] rowBase_q
);

    // ============================================================
    // helpers
    // ============================================================
    // table ops never use the window, whatever the address
    function automatic logic isTable(input psda_op_e op);
        return op == PSDA_OP_RDLO || op == PSDA_OP_RDHI ||
               op == PSDA_OP_WRLO || op == PSDA_OP_WRHI;
    endfunction

    function automatic logic [7:0] pickByte(input logic [15:0] w, input logic sel);
        return sel ? w[15:8] : w[7:0];
    endfunction

    function automatic logic isRead(input psda_op_e op);
        return op == PSDA_OP_RDLO || op == PSDA_OP_RDHI;
    endfunction

    function automatic logic isWrite(input psda_op_e op);
        return op == PSDA_OP_WRLO || op == PSDA_OP_WRHI;
    endfunction

    // word slot inside a write row; rows hold 64 words two addresses apart
    function automatic logic [5:0] rowSlot(input logic [23:0] addr);
        return 6'((addr >> 1) % `PSDA_ROW_WORDS);
    endfunction

    // word slot inside an erase page of 512 words
    function automatic logic [8:0] pageSlot(input logic [23:0] addr);
        return 9'((addr >> 1) % `PSDA_PAGE_WORDS);
    endfunction

    // first address of the row, so a buffer load can be checked for alignment
    function automatic logic [15:0] rowStart(input logic [23:0] addr);
        return {addr[15:7], 7'h00};
    endfunction

    // ============================================================
    // decode
    // ============================================================
    // request class
    logic        tableOp;
    logic        winHit;
    logic        byteSel;
    logic        program_window_enable;

    // addresses
    logic [23:0] tableAddr;
    logic [23:0] winAddr;

    // stall and steering
    logic [1:0]  stall;
    logic        repEdge;
    logic [15:0] rdWord;
    logic [7:0]  hiByte;
    logic [23:0] wrWord;
    logic [2:0]  wrLanes;

    // next command
    psda_cmd_s   cmd_d;

    always_comb begin
        tableOp = isTable(req.op);
        program_window_enable = core_control_reg[`PSDA_WIN_ENABLE_BIT];
        byteSel = req.effAddr[0];
        // table ops bypass the window so a table pointer in the upper half is never remapped
        winHit = (req.op == PSDA_OP_DATA) && req.effAddr[`PSDA_EA_MSB]
                 && program_window_enable && !tableOp;
    end

    // ============================================================
    // address forming
    // ============================================================
    // table ops reach either space through the page top bit
    // the window can only reach user space, so its top bit is tied low
    always_comb begin
        tableAddr = {table_page_select, req.effAddr};
        winAddr = {1'b0, visibility_page_select,
                   req.effAddr[`PSDA_WIN_LOW_BITS-1:0]};
    end

    // ============================================================
    // stall count
    // ============================================================
    // the count rides with the command so the sequencer can hold the core
    always_comb begin
        // any edge of the loop pays the full two cycles, middle passes pay none
        repEdge = req.repFirst || req.repLast || req.irqExit || req.irqReentry;
        stall = `PSDA_FAST_STALL;
        if (winHit) begin
            if (req.inRepeat) begin
                if (repEdge) begin
                    stall = `PSDA_OTHER_STALL;
                end else begin
                    stall = `PSDA_FAST_STALL;
                end
            end else if (req.isMove) begin
                stall = `PSDA_MOVE_STALL;
            end else begin
                stall = `PSDA_OTHER_STALL;
            end
        end
    end

    // ============================================================
    // read steering
    // ============================================================
    // byte reads clear the upper data byte so a stale value never leaks
    always_comb begin
        hiByte = progRdData[23:16];
        rdWord = ramRdData;
        unique case (req.op)
            PSDA_OP_RDLO: begin
                if (req.byteMode) begin
                    rdWord = {8'h00, pickByte(progRdData[15:0], byteSel)};
                end else begin
                    rdWord = progRdData[15:0];
                end
            end
            PSDA_OP_RDHI: begin
                if (req.byteMode) begin
                    rdWord = {8'h00, byteSel ? 8'h00 : hiByte};
                end else begin
                    rdWord = {8'h00, hiByte};
                end
            end
            PSDA_OP_DATA: begin
                rdWord = winHit ? progRdData[15:0] : ramRdData;
            end
            PSDA_OP_NONE, PSDA_OP_WRLO, PSDA_OP_WRHI: begin
                rdWord = 16'h0000;
            end
            // codes 6 and 7 are unused; answer zero rather than stale data
            default: begin
                rdWord = 16'h0000;
            end
        endcase
    end

    // ============================================================
    // write steering
    // ============================================================
    // lanes: bit 0 low byte, bit 1 middle byte, bit 2 upper byte
    // a low byte write repeats the byte on both low lanes; the lane mask picks one
    always_comb begin
        wrWord = 24'h000000;
        wrLanes = 3'h0;
        if (req.op == PSDA_OP_WRLO) begin
            if (req.byteMode) begin
                wrWord = {8'h00, req.wrData[7:0], req.wrData[7:0]};
                wrLanes = byteSel ? 3'h2 : 3'h1;
            end else begin
                wrWord = {8'h00, req.wrData};
                wrLanes = 3'h3;
            end
        end else if (req.op == PSDA_OP_WRHI) begin
            // the phantom byte has no storage, so a byte write to it writes nothing
            wrWord = {req.wrData[7:0], 16'h0000};
            wrLanes = (req.byteMode && byteSel) ? 3'h0 : 3'h4;
        end
    end

    // ============================================================
    // command build
    // ============================================================
    // ram address always rides along; it is ignored when a program space is picked
    always_comb begin
        cmd_d = '0;
        cmd_d.valid = req.op != PSDA_OP_NONE;
        cmd_d.ramAddr = req.effAddr;
        cmd_d.stallCycles = stall;
        cmd_d.progWrData = wrWord;
        cmd_d.progWrLanes = wrLanes;
        if (tableOp) begin
            cmd_d.space = table_page_select[`PSDA_CFG_SPACE_BIT] ?
                          PSDA_PROG_CFG : PSDA_PROG_USER;
            cmd_d.progAddr = tableAddr;
            cmd_d.progRead = isRead(req.op);
            cmd_d.progWrite = isWrite(req.op);
        end else if (winHit) begin
            cmd_d.space = PSDA_PROG_WIN;
            cmd_d.progAddr = winAddr;
            cmd_d.progRead = 1'b1;
        end else begin
            cmd_d.space = PSDA_PROG_RAM;
        end
    end

    // ============================================================
    // registered outputs
    // ============================================================
    // one stage only: the answer lands exactly one edge after the request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd_q <= '0;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // read data is reloaded on every edge; an idle or write cycle loads zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= rdWord;
        end
    end

    // ram reads count as reads too, so the core can latch either source the same way
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= isRead(req.op) || req.op == PSDA_OP_DATA;
        end
    end

    // flags the cycle after a table op, while the window is held off
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tableBusy_q <= 1'b0;
        end else begin
            tableBusy_q <= tableOp;
        end
    end

    // ============================================================
    // self-programming geometry
    // ============================================================
    // row and page positions let the flash sequencer check write-buffer alignment
    // they hold between table ops so the sequencer may look at them late
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rowIndex_q <= 6'h00;
        end else if (tableOp) begin
            rowIndex_q <= rowSlot(tableAddr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pageIndex_q <= 9'h000;
        end else if (tableOp) begin
            pageIndex_q <= pageSlot(tableAddr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rowBase_q <= 16'h0000;
        end else if (tableOp) begin
            rowBase_q <= rowStart(tableAddr);
        end
    end

endmodule // psda_bridge
`default_nettype wire

// File: verif/psda_bridge_asserts.sv
// Purpose: port-level checker for the program space data access bridge
// Assumes: answer one edge after each request
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module psda_bridge_chk
    import psda_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire psda_req_s   req,
    input wire logic [7:0]  table_page_select,
    input wire logic [7:0]  visibility_page_select,
    input wire logic [15:0] core_control_reg,
    input wire logic [23:0] progRdData,
    input wire logic [15:0] ramRdData,
    input wire psda_cmd_s   cmd_q,
    input wire logic [15:0] rdData_q,
    input wire logic        tableBusy_q,
    input wire logic [5:0]  rowIndex_q
);
    // ==========================================
    // helpers
    wire logic tblOp = req.op inside {PSDA_OP_RDLO, PSDA_OP_RDHI, PSDA_OP_WRLO, PSDA_OP_WRHI};
    wire logic winOp = req.op == PSDA_OP_DATA && req.effAddr[15] && core_control_reg[2];
    wire logic ramOp = req.op == PSDA_OP_DATA && !winOp;
    wire logic repEdge = req.repFirst | req.repLast | req.irqExit | req.irqReentry;
    wire logic rdLo = req.op == PSDA_OP_RDLO;
    wire logic rdHi = req.op == PSDA_OP_RDHI;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ==========================================
    // assertions
    AST_TBL_ADDR: assert property (tblOp |=> cmd_q.progAddr ==
        {$past(table_page_select), $past(req.effAddr)}) else $error("table address wrong");
    AST_TBL_SPACE: assert property (tblOp |=> cmd_q.space ==
        ($past(table_page_select[7]) ? PSDA_PROG_CFG : PSDA_PROG_USER)) else $error("table space");
    AST_RDLO_WORD: assert property (rdLo && !req.byteMode |=>
        rdData_q == $past(progRdData[15:0])) else $error("low word read");
    AST_RDLO_BYTE: assert property (rdLo && req.byteMode |=> rdData_q[7:0] ==
        ($past(req.effAddr[0]) ? $past(progRdData[15:8]) : $past(progRdData[7:0])))
        else $error("low byte read");
    AST_RDHI_WORD: assert property (rdHi && !req.byteMode |=>
        rdData_q == {8'h00, $past(progRdData[23:16])}) else $error("high word read");
    AST_RDHI_PHANTOM: assert property (rdHi && req.byteMode && req.effAddr[0] |=>
        rdData_q[7:0] == 8'h00) else $error("phantom byte not zero");
    AST_WIN_MAP: assert property (winOp |=> cmd_q.space == PSDA_PROG_WIN &&
        cmd_q.progAddr == {1'b0, $past(visibility_page_select), $past(req.effAddr[14:0])}
        && rdData_q == $past(progRdData[15:0])) else $error("window map");
    AST_WIN_STALL: assert property (winOp && !req.inRepeat |=>
        cmd_q.stallCycles == ($past(req.isMove) ? 2'h1 : 2'h2)) else $error("window stall");
    AST_REP_STALL: assert property (winOp && req.inRepeat |=>
        cmd_q.stallCycles == ($past(repEdge) ? 2'h2 : 2'h0)) else $error("repeat stall");
    AST_RAM_PATH: assert property (ramOp |=> cmd_q.space == PSDA_PROG_RAM &&
        cmd_q.stallCycles == 2'h0 && rdData_q == $past(ramRdData)) else $error("ram path");
    AST_TBL_BUSY: assert property (tblOp |=> tableBusy_q && cmd_q.space != PSDA_PROG_WIN)
        else $error("table busy");
    AST_ROW_SLOT: assert property (tblOp |=> rowIndex_q == $past(req.effAddr[6:1]))
        else $error("row slot");
endmodule // psda_bridge_chk
`default_nettype wire

// File: verif/psda_core_model.sv
// Purpose: far side model giving program and ram read data
// Assumes: data valid in the same cycle as the request
// Notes:   content tied to address so a wrong lane shows
`timescale 1ns/1ps
`default_nettype none
module psda_core_model
    import psda_pkg::*;
(
    input  wire psda_req_s   req,
    input  wire logic [7:0]  pageSel,
    output var  logic [23:0] progRdData,
    output var  logic [15:0] ramRdData
);
    // ==========================================
    // every byte differs so steering slips cannot hide
    assign progRdData = {pageSel ^ req.effAddr[15:8], req.effAddr ^ 16'h5AC3};
    assign ramRdData  = ~req.effAddr;
endmodule // psda_core_model
`default_nettype wire

// File: verif/psda_bridge_tb.sv
// Purpose: self-checking bench for the bridge
// Assumes: inputs driven on the falling edge
// Notes:   answers sampled one falling edge after the request
`timescale 1ns/1ps
`default_nettype none
module psda_bridge_tb
    import psda_pkg::*;
;
    logic        ref_clk;
    logic        reset;
    psda_req_s   req;
    logic [7:0]  tblPage;
    logic [7:0]  visPage;
    logic [15:0] coreCtl;
    logic [23:0] progRdData;
    logic [15:0] ramRdData;
    psda_cmd_s   cmd;
    logic [15:0] rdData;
    logic        rdValid;
    logic        tableBusy;
    logic [5:0]  rowIdx;
    logic [8:0]  pageIdx;
    logic [15:0] rowBase;
    logic [23:0] pv;
    logic [15:0] rv;
    int          fails;
    int          samples_checked;
    // ==========================================
    psda_bridge i_dut (.ref_clk(ref_clk), .reset(reset), .req(req),
        .table_page_select(tblPage), .visibility_page_select(visPage),
        .core_control_reg(coreCtl), .progRdData(progRdData), .ramRdData(ramRdData),
        .cmd_q(cmd), .rdData_q(rdData), .rdValid_q(rdValid), .tableBusy_q(tableBusy),
        .rowIndex_q(rowIdx), .pageIndex_q(pageIdx), .rowBase_q(rowBase));
    psda_core_model i_core (.req(req), .pageSel(tblPage ^ visPage),
        .progRdData(progRdData), .ramRdData(ramRdData));
    always #20 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // rep holds inRepeat, first, last, irq exit, irq re-entry
    task automatic issue(input psda_op_e op, input logic bm, input logic [15:0] ea,
                         input logic mv, input logic [4:0] rep);
        req = '{op, bm, ea, ~ea, mv, rep[4], rep[3], rep[2], rep[1], rep[0]};
        #1 pv = progRdData;
        rv = ramRdData;
        @(negedge ref_clk);
    endtask
    // ==========================================
    // every table op, both sizes, both selects, both spaces, window bit set
    task automatic sc_table();
        psda_op_e    op;
        logic [15:0] ea;
        logic [15:0] exp;
        logic [15:0] mask;
        logic [2:0]  lanes;
        logic [23:0] laneMask;
        logic [23:0] wrExp;
        for (int i = 0; i < 32; i++) begin
            op = psda_op_e'(3'(i[3:2]) + 3'h1);
            ea = {1'b1, 14'(14'h2C69 + i * 179), i[0]};
            tblPage = {i[4], 7'h35};
            coreCtl = 16'h0004;
            issue(op, i[1], ea, 1'b0, 5'h00);
            mask = i[1] ? 16'h00FF : 16'hFFFF;
            exp = (op == PSDA_OP_RDLO) ? (i[1] ? {8'h00, i[0] ? pv[15:8] : pv[7:0]} : pv[15:0])
                : {8'h00, (i[1] && i[0]) ? 8'h00 : pv[23:16]};
            if (op inside {PSDA_OP_RDLO, PSDA_OP_RDHI}) begin
                check("rdData", 24'(rdData & mask), 24'(exp & mask));
            end
            check("progAddr", cmd.progAddr, {tblPage, ea});
            check("space", 24'(cmd.space), 24'(tblPage[7]));
            check("dir", 24'({cmd.progRead, cmd.progWrite}), i[3] ? 24'h1 : 24'h2);
            check("flags", 24'({cmd.valid, rdValid, tableBusy}), i[3] ? 24'h5 : 24'h7);
            lanes = (op == PSDA_OP_WRLO) ? (i[1] ? (i[0] ? 3'h2 : 3'h1) : 3'h3)
                  : (op == PSDA_OP_WRHI && !(i[1] && i[0])) ? 3'h4 : 3'h0;
            laneMask = {{8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
            wrExp = (op == PSDA_OP_WRHI) ? {~ea[7:0], 16'h0000}
                  : {8'h00, i[1] ? {2{~ea[7:0]}} : ~ea};
            check("wrLanes", 24'(cmd.progWrLanes), 24'(lanes));
            check("wrData", cmd.progWrData & laneMask, wrExp & laneMask);
            check("rowIdx", 24'(rowIdx), 24'((ea >> 1) % 64));
            check("pageIdx", 24'(pageIdx), 24'((ea >> 1) % 512));
            check("rowBase", 24'(rowBase), 24'(ea - ea % 128));
        end
    endtask
    task automatic sc_window();
        logic [4:0] rep;
        for (int j = 0; j < 8; j++) begin
            rep = (j < 2) ? 5'h00 : (j < 6) ? (5'h10 | (5'h10 >> (j - 1))) : 5'h10;
            visPage = 8'(8'hA5 + j);
            coreCtl = 16'h0004;
            issue(PSDA_OP_DATA, 1'b0, 16'(16'hC3C5 ^ j), j == 0 || j == 7, rep);
            check("winAddr", cmd.progAddr, {1'b0, visPage, req.effAddr[14:0]});
            check("winData", 24'(rdData), 24'(pv[15:0]));
            check("stall", 24'(cmd.stallCycles), j == 0 ? 24'h1 : j < 6 ? 24'h2 : 24'h0);
            check("winFlags", 24'({cmd.valid, rdValid, tableBusy, cmd.progRead}), 24'hD);
        end
    endtask
    task automatic sc_ram();
        for (int k = 0; k < 2; k++) begin
            coreCtl = k ? 16'hFFFB : 16'h0004;
            issue(PSDA_OP_DATA, 1'b0, {k[0], 15'h1E2D}, 1'b0, 5'h00);
            check("ramSpace", 24'(cmd.space), 24'h3);
            check("ramStall", 24'(cmd.stallCycles), 24'h0);
            check("ramData", 24'(rdData), 24'(rv));
            check("ramAddr", 24'(cmd.ramAddr), 24'({k[0], 15'h1E2D}));
            check("ramFlags", 24'({cmd.valid, rdValid, tableBusy, cmd.progRead}), 24'hC);
        end
    endtask
    // a reset in mid-run must clear every registered output
    task automatic sc_reset();
        issue(PSDA_OP_WRHI, 1'b0, 16'h0ABE, 1'b0, 5'h00);
        req = '0;
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        check("rstOut", 24'({cmd.valid, rdValid, tableBusy, rdData}), 24'h0);
        check("rstGeom", 24'({rowIdx, pageIdx}), 24'h0);
        check("rstBase", 24'(rowBase), 24'h0);
    endtask
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        req = '0;
        tblPage = 8'h00;
        visPage = 8'h00;
        coreCtl = 16'h0000;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        check("idleValid", 24'(cmd.valid), 24'h0);
        sc_table();
        sc_window();
        sc_ram();
        sc_reset();
        close_out();
    end
    // whole run is about fifty cycles; this span is far beyond it
    initial begin
        #20000;
        fails++;
        close_out();
    end
endmodule // psda_bridge_tb
bind psda_bridge psda_bridge_chk i_chk (.ref_clk(ref_clk), .reset(reset), .req(req),
    .table_page_select(table_page_select), .visibility_page_select(visibility_page_select),
    .core_control_reg(core_control_reg), .progRdData(progRdData), .ramRdData(ramRdData),
    .cmd_q(cmd_q), .rdData_q(rdData_q), .tableBusy_q(tableBusy_q), .rowIndex_q(rowIndex_q));
`default_nettype wire
